//--- include/pbsp_pkg.sv
// shared constants and types of the pipelined burst memory port
package pbsp_pkg;
	// geometry
	localparam int ADDR_W = 21;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int BYTE_W = 8;
	localparam int DATA_W = 32;
	localparam int WORD_W = 36;
	localparam int BURST_W = 2;
	// timing: sleep pin is seen after two synchroniser stages
	localparam int CLK_PERIOD_NS = 50;
	localparam int SYNC_STAGES = 2;
	// burst counter
	localparam logic [BURST_W-1:0] BURST_START = 2'h0;
	localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
	// lane masks
	localparam logic [LANES-1:0] ALL_LANES = 4'hF;
	localparam logic [LANES-1:0] NO_LANES = 4'h0;
	// order strap reset value: interleaved, as the pull-up gives
	localparam logic [SYNC_STAGES-1:0] MODE_SYNC_RST = 2'h3;
	localparam logic [SYNC_STAGES-1:0] SLEEP_SYNC_RST = 2'h0;

	typedef enum logic [2:0] {
		PBSP_DESEL = 3'h1,
		PBSP_SEL = 3'h2,
		PBSP_SLEEP = 3'h4
	} pbsp_state_t;
endpackage

//--- hw/pbsp_mem.sv
// storage array with per-lane write and registered read data
`timescale 1ns/10ps
`default_nettype none

module pbsp_mem #(
	parameter int ADDR_W = pbsp_pkg::ADDR_W,
	parameter int LANES = pbsp_pkg::LANES,
	parameter int LANE_W = pbsp_pkg::LANE_W
) (
	// clock
	input wire logic clk,
	// read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [LANES*LANE_W-1:0] rd_data,
	// write port
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [LANES-1:0] wr_lane,
	input wire logic [LANES*LANE_W-1:0] wr_data
);

	if (ADDR_W < 3 || LANES < 1 || LANE_W < 1) begin : g_chk
		$error("pbsp_mem: unsupported geometry");
	end

	////////////////////////////////////////////////////////////////////////
	// one array per lane, so an unselected lane is never touched
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [LANE_W-1:0] lane_mem [0:(2**ADDR_W)-1];

		always_ff @(posedge clk) begin
			if (wr_lane[i]) begin
				lane_mem[wr_addr] <= wr_data[i*LANE_W +: LANE_W];
			end
		end

		// read before write: old word when both hit one address
		always_ff @(posedge clk) begin
			rd_data[i*LANE_W +: LANE_W] <= lane_mem[rd_addr];
		end
	end

endmodule

`default_nettype wire

//--- hw/pbsp_port.sv
// pipelined burst static memory port: decode, burst counter, data path
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - all synchronous inputs are captured on the rising clock edge
// - new address only when a strobe is low and all selects active
// - accepted strobe loads full address and low two bits into counter
// - selected when select1 low, select2 high, select3 low, at load only
// - processor strobe ignored whenever select1 is high
// - both strobes low: processor strobe wins, controller strobe ignored
// - step low during a burst moves the counter to the next address
// - all-bytes write low writes all four lanes, ignoring lane controls
// - byte write needs enable low, writes only lanes whose select is low
// - address, data, controls registered, array written on the next clock edge
// - write data on data and parity lines captured at rising edge
// - read data appear one clock after address, via output registers
// - lines driven only while output enable low, released at once
// - first clock of read after deselect keeps outputs released
// - pipelined burst timing three-one-one-one clocks
// - deselect takes effect within the sampled cycle, no dead cycle
// - order strap low gives linear, high gives interleaved, static
// - sleep input high enters low-power state keeping stored data
// - linear adds count to start, interleaved xors count with start
// - processor-strobe write: controls ignored first clock, used second
// - lines released whenever a write cycle is detected
module pbsp_port #(
	parameter int ADDR_W = pbsp_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// address, strobes, burst step
	input wire logic [ADDR_W-1:0] addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_step_n,
	// chip selects
	input wire logic chip_sel1_n,
	input wire logic chip_sel2,
	input wire logic chip_sel3_n,
	// write controls
	input wire logic all_bytes_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [pbsp_pkg::LANES-1:0] byte_lane_select_n,
	// asynchronous and static pins
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic burst_order_interleaved,
	// data lines
	input wire logic [pbsp_pkg::DATA_W-1:0] data_lines_in,
	output logic [pbsp_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	// parity lines
	input wire logic [pbsp_pkg::LANES-1:0] parity_lane_lines_in,
	output logic [pbsp_pkg::LANES-1:0] parity_lane_lines_out,
	output logic parity_lane_lines_oe
);

	localparam int LANES = pbsp_pkg::LANES;
	localparam int LANE_W = pbsp_pkg::LANE_W;
	localparam int BYTE_W = pbsp_pkg::BYTE_W;
	localparam int BW = pbsp_pkg::BURST_W;

	if (ADDR_W < 3 || pbsp_pkg::LANES * pbsp_pkg::LANE_W
		!= pbsp_pkg::WORD_W) begin : g_chk
		$error("pbsp_port: unsupported geometry");
	end

	////////////////////////////////////////////////////////////////////////
	// declarations
	pbsp_pkg::pbsp_state_t state_reg;
	logic [pbsp_pkg::SYNC_STAGES-1:0] sleep_sync_reg;
	logic [pbsp_pkg::SYNC_STAGES-1:0] mode_sync_reg;
	logic sleep_active;
	logic interleaved;
	logic chip_sel;
	logic strobe_p;
	logic strobe_c;
	logic strobe_any;
	logic load;
	logic desel;
	logic cont;
	logic step;
	logic do_write;
	logic do_read;
	logic [LANES-1:0] wr_lanes;
	logic [BW-1:0] start_reg;
	logic [BW-1:0] count_reg;
	logic [BW-1:0] count_next;
	logic [BW-1:0] low_next;
	logic [ADDR_W-1:0] cur_addr_reg;
	logic [LANES*LANE_W-1:0] din_word;
	logic [LANES*LANE_W-1:0] wr_data_reg;
	logic [LANES-1:0] wr_lane_reg;
	logic [LANES*LANE_W-1:0] rd_word;
	logic acc_rd_reg;
	logic out_valid_reg;
	logic emerging_reg;
	logic emerge_first_reg;
	logic wr_pend;
	logic drive;

	////////////////////////////////////////////////////////////////////////
	// asynchronous sleep pin and static order strap
	// two stages also give the two-clock sleep entry and exit
	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_sync_reg <= pbsp_pkg::SLEEP_SYNC_RST;
		end else begin
			sleep_sync_reg <= {sleep_sync_reg[0], sleep_request};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_sync_reg <= pbsp_pkg::MODE_SYNC_RST;
		end else begin
			mode_sync_reg <= {mode_sync_reg[0], burst_order_interleaved};
		end
	end

	assign sleep_active = sleep_sync_reg[pbsp_pkg::SYNC_STAGES-1];
	// strap assumed static; a change mid-burst reorders the rest
	assign interleaved = mode_sync_reg[pbsp_pkg::SYNC_STAGES-1];

	////////////////////////////////////////////////////////////////////////
	// strobe and select decode, sampled at the rising edge
	assign chip_sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	assign strobe_p = !processor_addr_strobe_n && !chip_sel1_n;
	assign strobe_c = !controller_addr_strobe_n && !strobe_p;
	// no access in the one cycle that leaves sleep
	assign strobe_any = (strobe_p || strobe_c) && !sleep_active
		&& (state_reg != pbsp_pkg::PBSP_SLEEP);
	assign load = strobe_any && chip_sel;
	assign desel = strobe_any && !chip_sel;
	assign cont = (state_reg == pbsp_pkg::PBSP_SEL) && !strobe_any
		&& !sleep_active;
	assign step = cont && !burst_step_n;

	// all-bytes write overrides lane controls
	always_comb begin
		if (!all_bytes_write_n) begin
			wr_lanes = pbsp_pkg::ALL_LANES;
		end else if (!byte_write_enable_n) begin
			wr_lanes = ~byte_lane_select_n;
		end else begin
			wr_lanes = pbsp_pkg::NO_LANES;
		end
	end

	// processor-strobe load ignores write controls; next edge decides
	assign do_write = ((load && !strobe_p) || cont)
		&& (wr_lanes != pbsp_pkg::NO_LANES);
	assign do_read = (load || cont) && !do_write;

	////////////////////////////////////////////////////////////////////////
	// selection state
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= pbsp_pkg::PBSP_DESEL;
		end else if (sleep_active) begin
			state_reg <= pbsp_pkg::PBSP_SLEEP;
		end else begin
			case (state_reg)
				pbsp_pkg::PBSP_SLEEP: begin
					state_reg <= pbsp_pkg::PBSP_DESEL;
				end
				default: begin
					if (load) begin
						state_reg <= pbsp_pkg::PBSP_SEL;
					end else if (desel) begin
						state_reg <= pbsp_pkg::PBSP_DESEL;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-bit wrapping burst counter
	assign count_next = count_reg + pbsp_pkg::BURST_ONE;
	// modulo-four arithmetic gives the wrap with no extra logic
	assign low_next = interleaved ? (start_reg ^ count_next)
		: (start_reg + count_next);

	always_ff @(posedge clk) begin
		if (rst) begin
			start_reg <= pbsp_pkg::BURST_START;
			count_reg <= pbsp_pkg::BURST_START;
		end else if (load) begin
			start_reg <= addr[BW-1:0];
			count_reg <= pbsp_pkg::BURST_START;
		end else if (step) begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_addr_reg <= '0;
		end else if (load) begin
			cur_addr_reg <= addr;
		end else if (step) begin
			cur_addr_reg[BW-1:0] <= low_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write path: capture now, array write on the next edge
	for (genvar i = 0; i < LANES; i++) begin : g_pack
		assign din_word[i*LANE_W +: LANE_W] = {parity_lane_lines_in[i],
			data_lines_in[i*BYTE_W +: BYTE_W]};
		assign data_lines_out[i*BYTE_W +: BYTE_W] =
			rd_word[i*LANE_W +: BYTE_W];
		assign parity_lane_lines_out[i] = rd_word[i*LANE_W + BYTE_W];
	end

	always_ff @(posedge clk) begin
		wr_data_reg <= din_word;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_lane_reg <= pbsp_pkg::NO_LANES;
		end else begin
			wr_lane_reg <= do_write ? wr_lanes : pbsp_pkg::NO_LANES;
		end
	end

	assign wr_pend = (wr_lane_reg != pbsp_pkg::NO_LANES);

	// cur_addr_reg still holds the write cycle's address at that edge unless that cycle also stepped the burst
	pbsp_mem #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_mem (
		.clk(clk),
		.rd_addr(cur_addr_reg),
		.rd_data(rd_word),
		.wr_addr(cur_addr_reg),
		.wr_lane(wr_lane_reg),
		.wr_data(wr_data_reg)
	);

	////////////////////////////////////////////////////////////////////////
	// read pipeline and output drive
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_rd_reg <= 1'b0;
			out_valid_reg <= 1'b0;
			emerge_first_reg <= 1'b0;
			emerging_reg <= 1'b0;
		end else begin
			acc_rd_reg <= do_read;
			out_valid_reg <= acc_rd_reg && !desel && !sleep_active;
			emerge_first_reg <= load && (state_reg != pbsp_pkg::PBSP_SEL);
			// mask must cover the cycle in which the first word stands
			emerging_reg <= emerge_first_reg;
		end
	end

	// output enable pin gates the drivers with no register in the path
	assign drive = out_valid_reg && !output_enable_n
		&& !emerging_reg
		&& !wr_pend
		&& (state_reg == pbsp_pkg::PBSP_SEL);
	assign data_lines_oe = drive;
	assign parity_lane_lines_oe = drive;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	addr_load_a: assert property (load |=> cur_addr_reg == $past(addr)
		&& count_reg == pbsp_pkg::BURST_START)
		else $error("address not loaded on accepted strobe");

	strobe_gate_a: assert property ((processor_addr_strobe_n
		&& controller_addr_strobe_n && !sleep_active
		&& state_reg == pbsp_pkg::PBSP_DESEL) |=>
		state_reg == pbsp_pkg::PBSP_DESEL)
		else $error("selected without a strobe");

	ce1_ignore_a: assert property ((chip_sel1_n && controller_addr_strobe_n
		&& !sleep_active && state_reg == pbsp_pkg::PBSP_DESEL) |=>
		state_reg == pbsp_pkg::PBSP_DESEL)
		else $error("processor strobe taken with select1 high");

	strobe_prio_a: assert property ((!processor_addr_strobe_n
		&& !controller_addr_strobe_n && load && !all_bytes_write_n) |=>
		!wr_pend)
		else $error("controller strobe acted beside processor strobe");

	desel_now_a: assert property (desel |=> !data_lines_oe
		&& state_reg != pbsp_pkg::PBSP_SEL)
		else $error("deselect did not act in one cycle");

	all_bytes_a: assert property ((do_write && !all_bytes_write_n) |=>
		wr_lane_reg == pbsp_pkg::ALL_LANES)
		else $error("all-bytes write missed a lane");

	lane_sel_a: assert property ((do_write && all_bytes_write_n) |=>
		wr_lane_reg == ~$past(byte_lane_select_n))
		else $error("byte write lanes wrong");

	linear_step_a: assert property ((step && !interleaved) |=>
		cur_addr_reg[BW-1:0] == $past(cur_addr_reg[BW-1:0])
		+ pbsp_pkg::BURST_ONE)
		else $error("linear burst step wrong");

	inter_step_a: assert property ((step && interleaved) |=>
		cur_addr_reg[BW-1:0] == ($past(start_reg) ^ $past(count_next)))
		else $error("interleaved burst step wrong");

	read_lat_a: assert property ((do_read && !output_enable_n) ##1
		(!desel && !sleep_active && !wr_pend && !output_enable_n
		&& !do_write)
		|=> data_lines_oe || emerging_reg)
		else $error("read data not driven one clock after address");

	oe_mask_a: assert property (output_enable_n |-> !data_lines_oe
		&& !parity_lane_lines_oe)
		else $error("driving with output enable high");

	emerge_mask_a: assert property ((load
		&& state_reg == pbsp_pkg::PBSP_DESEL) |=> ##1 !data_lines_oe)
		else $error("drove in first clock after deselect");

	write_mask_a: assert property (do_write |=> !data_lines_oe)
		else $error("driving during a write cycle");

	sleep_enter_a: assert property ($rose(sleep_request) ##1
		sleep_request |=> ##1 state_reg == pbsp_pkg::PBSP_SLEEP)
		else $error("sleep not entered within two clocks");

	read_cover_c: cover property (load && do_read ##3 data_lines_oe);
	pwrite_cover_c: cover property (load && strobe_p ##1 do_write);
	burst_cover_c: cover property (load ##1 step [*3]);
	sleep_cover_c: cover property (state_reg == pbsp_pkg::PBSP_SLEEP);

endmodule

`default_nettype wire

//--- verif/pbsp_bus_master_model.sv
// far-side bus model: resolves the shared data and parity lines
`timescale 1ns/10ps
`default_nettype none

module pbsp_bus_master_model (
	// clock
	input wire logic clk,
	// device side
	input wire logic [35:0] dev_word,
	input wire logic dev_oe,
	// master side
	input wire logic [35:0] mst_word,
	input wire logic mst_oe,
	// resolved lines
	output logic [35:0] line_word
);
	logic [35:0] last_reg;

	////////////////////////////////////////////////////////////////////////
	// released lines show the inverse of the last level, never a held value
	always_comb begin
		if (dev_oe) begin
			line_word = dev_word;
		end else if (mst_oe) begin
			line_word = mst_word;
		end else begin
			line_word = ~last_reg;
		end
	end

	always_ff @(posedge clk) begin
		last_reg <= line_word;
	end
endmodule

`default_nettype wire

//--- verif/test_pipelined_burst_sram_port.sv
// self-checking bench of the pipelined burst memory port
`timescale 1ns/10ps
`default_nettype none

module test_pipelined_burst_sram_port;
	// small array keeps the run short
	localparam int AW = 6;
	logic clk = 1'h0, rst = 1'h1;
	logic [AW-1:0] addr = 6'h00;
	logic p_n = 1'h1, c_n = 1'h1, step_n = 1'h1;
	logic sel1_n = 1'h1, sel2 = 1'h0, sel3_n = 1'h1;
	logic gw_n = 1'h1, bwe_n = 1'h1, oe_n = 1'h0, sleep = 1'h0, ilv = 1'h0;
	logic [3:0] lane_n = 4'hF;
	logic [35:0] m_word = 36'h0;
	wire logic [35:0] line_word, d_out;
	logic m_oe = 1'h1;
	wire logic [1:0] d_oe;
	logic [35:0] exp_mem [64];
	int num_errors = 0, n_checks = 0;

	pbsp_port #(.ADDR_W(AW)) u_pbsp_port (
		.clk(clk), .rst(rst), .addr(addr),
		.processor_addr_strobe_n(p_n), .controller_addr_strobe_n(c_n),
		.burst_step_n(step_n), .chip_sel1_n(sel1_n), .chip_sel2(sel2),
		.chip_sel3_n(sel3_n), .all_bytes_write_n(gw_n),
		.byte_write_enable_n(bwe_n), .byte_lane_select_n(lane_n),
		.output_enable_n(oe_n), .sleep_request(sleep),
		.burst_order_interleaved(ilv), .data_lines_in(line_word[31:0]),
		.data_lines_out(d_out[31:0]), .data_lines_oe(d_oe[1]),
		.parity_lane_lines_in(line_word[35:32]),
		.parity_lane_lines_out(d_out[35:32]),
		.parity_lane_lines_oe(d_oe[0])
	);

	pbsp_bus_master_model u_pbsp_bus_master_model (
		.clk(clk), .dev_word(d_out), .dev_oe(d_oe[1]),
		.mst_word(m_word), .mst_oe(m_oe), .line_word(line_word)
	);

	always #(pbsp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cyc();
		@(posedge clk);
		#1;
	endtask

	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: word %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk_oe(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: enables %b not %b", $time, got, exp);
		end
	endtask

	task automatic idle();
		{p_n, c_n, step_n, gw_n, bwe_n, m_oe} = 6'h3E;
		lane_n = 4'hF;
	endtask

	task automatic reset_dut();
		rst = 1'h1;
		repeat (2) cyc();
		rst = 1'h0;
		idle();
		// strap is seen two edges after release
		repeat (3) cyc();
	endtask

	function automatic logic [35:0] word_of(input int i);
		return {i[3:0], 4'hC, i[3:0] ^ 4'h5, 24'hA50F3C};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// controller-strobe deselect with the given select pattern
	task automatic desel(input logic [2:0] s);
		{sel1_n, sel2, sel3_n} = s;
		c_n = 1'h0;
		cyc();
		chk_oe(d_oe, 2'h0);
		idle();
	endtask

	task automatic wr_c(input logic [AW-1:0] a, input logic [35:0] w,
		input logic g, input logic b, input logic [3:0] l);
		addr = a;
		{sel1_n, sel2, sel3_n} = 3'h2;
		c_n = 1'h0;
		{gw_n, bwe_n, lane_n} = {g, b, l};
		m_word = w;
		m_oe = 1'h1;
		cyc();
		idle();
		chk_oe(d_oe, 2'h0);
		for (int i = 0; i < 4; i++) begin
			if (!g || (!b && !l[i])) begin
				exp_mem[a][8*i +: 8] = w[8*i +: 8];
				exp_mem[a][32+i] = w[32+i];
			end
		end
	endtask

	task automatic rd_burst(input logic [AW-1:0] a);
		logic [1:0] lo;
		addr = a;
		{sel1_n, sel2, sel3_n} = 3'h2;
		p_n = 1'h0;
		cyc();
		p_n = 1'h1;
		// pins carry a wrong address: the counter must supply it
		addr = ~a;
		for (int k = 0; k < 4; k++) begin
			step_n = (k < 3) ? 1'h0 : 1'h1;
			cyc();
			lo = ilv ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
			chk_word(d_out, exp_mem[{a[AW-1:2], lo}]);
			chk_oe(d_oe, (k == 0) ? 2'h0 : 2'h3);
		end
		oe_n = 1'h1;
		#1;
		chk_oe(d_oe, 2'h0);
		oe_n = 1'h0;
		desel(3'h6);
	endtask

	// both strobes low on the load edge: only the processor one counts
	task automatic wr_p(input logic [AW-1:0] a, input logic [35:0] w,
		input logic do_wr);
		addr = a;
		{sel1_n, sel2, sel3_n} = 3'h2;
		{p_n, c_n, gw_n} = 3'h0;
		m_word = ~w;
		m_oe = 1'h1;
		cyc();
		{p_n, c_n} = 2'h3;
		gw_n = !do_wr;
		m_word = w;
		cyc();
		idle();
		if (do_wr) begin
			exp_mem[a] = w;
		end
		desel(3'h3);
	endtask

	task automatic ign_p(input logic [AW-1:0] a, input logic [AW-1:0] b);
		addr = a;
		{sel1_n, sel2, sel3_n} = 3'h2;
		p_n = 1'h0;
		cyc();
		p_n = 1'h1;
		cyc();
		{sel1_n, p_n, addr} = {2'h2, b};
		cyc();
		chk_word(d_out, exp_mem[a]);
		chk_oe(d_oe, 2'h3);
		idle();
		desel(3'h0);
	endtask

	task automatic sleep_test();
		sleep = 1'h1;
		repeat (4) cyc();
		chk_oe(d_oe, 2'h0);
		sleep = 1'h0;
		repeat (3) cyc();
		rd_burst(6'h08);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset_dut();
		for (int i = 0; i < 12; i++) begin
			wr_c(i[AW-1:0], word_of(i), 1'h0, (i != 3), 4'h5);
		end
		wr_c(6'h09, 36'hF_FFFF_FFFF, 1'h1, 1'h0, 4'h9);
		wr_c(6'h0A, 36'h0_0000_0000, 1'h1, 1'h1, 4'h0);
		desel(3'h0);
		rd_burst(6'h01);
		rd_burst(6'h0B);
		ilv = 1'h1;
		reset_dut();
		rd_burst(6'h06);
		rd_burst(6'h09);
		wr_p(6'h04, 36'h3_1234_5678, 1'h1);
		wr_p(6'h05, 36'hC_8765_4321, 1'h0);
		rd_burst(6'h04);
		ign_p(6'h02, 6'h30);
		sleep_test();
		complete_run();
	end

	initial begin
		#(pbsp_pkg::CLK_PERIOD_NS * 2000);
		num_errors++;
		complete_run();
	end
endmodule

`default_nettype wire
